// File: hdl/fscfg_pkg.sv
// Purpose: constants for the frame pulse and frame numbering register slice
// Assumes: ahb-lite word registers, byte-wide data in bits 7:0
// Notes: register index times four gives the byte address
package fscfg_pkg;
    localparam logic [7:0] FSCFG_IDX_CTL = 8'h18;
    localparam logic [7:0] FSCFG_IDX_HIGH_UPPER = 8'h19;
    localparam logic [7:0] FSCFG_IDX_HIGH_LOWER = 8'h1a;
    localparam logic [7:0] FSCFG_IDX_LOW_UPPER = 8'h1b;
    localparam logic [7:0] FSCFG_IDX_LOW_LOWER = 8'h1c;
    localparam logic [7:0] FSCFG_IDX_LIMIT_UPPER = 8'h1d;
    localparam logic [7:0] FSCFG_IDX_LIMIT_LOWER = 8'h1e;
    localparam logic [7:0] FSCFG_IDX_RATE = 8'h1f;
    localparam logic [7:0] FSCFG_IDX_FWD = 8'h20;
    localparam logic [7:0] FSCFG_IDX_STATUS = 8'h21;
    localparam logic [7:0] FSCFG_RST_ZERO = 8'h00;
    localparam logic [7:0] FSCFG_RST_LIMIT_LOWER = 8'h04;
    localparam logic [7:0] FSCFG_RST_RATE = 8'h02;
    localparam logic [7:0] FSCFG_RST_FWD = 8'h30;
    localparam logic [7:0] FSCFG_RATE_MASK = 8'h0f;
    localparam logic [7:0] FSCFG_FWD_MASK = 8'hf0;
    localparam logic [7:0] FSCFG_CTL_MASK = 8'h07;
    localparam int FSCFG_CTL_ENABLE_BIT = 0;
    localparam int FSCFG_CTL_STYLE_BIT = 1;
    localparam int FSCFG_CTL_START_BIT = 2;
    localparam int FSCFG_FWD_PORT0_BIT = 4;
    localparam int FSCFG_FWD_PORT1_BIT = 5;
    localparam logic [1:0] FSCFG_HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] FSCFG_HSIZE_WORD = 3'b010;
endpackage : fscfg_pkg

// File: hdl/fscfg_pulse_gen.sv
// Purpose: frame pulse generator, high and low phases timed separately or 50/50
// Assumes: settings stable while running; a phase counts setting plus one cycles
// Notes: a new phase reloads its setting, so changes apply at the next phase edge
`timescale 1ns/1ns
module fscfg_pulse_gen (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pulse_generator_on,
    input wire logic pulse_timing_style,
    input wire logic pulse_start_level,
    input wire logic [15:0] pulse_high_setting,
    input wire logic [15:0] pulse_low_setting,
    output logic frame_pulse
);
    typedef struct packed {
        logic running;
        logic level;
        logic [23:0] count;
    } fscfg_gen_s;

    fscfg_gen_s s_q, s_d;
    logic [23:0] high_len, low_len, even_len;

    always_comb begin
        even_len = {pulse_high_setting[7:0], pulse_low_setting};
        // 50/50 style shares one 24-bit period for both phases
        high_len = pulse_timing_style ? even_len : {8'h00, pulse_high_setting};
        low_len = pulse_timing_style ? even_len : {8'h00, pulse_low_setting};
        s_d = s_q;
        if (!pulse_generator_on) begin
            s_d.running = 1'b0;
            s_d.level = pulse_start_level;
        end else if (!s_q.running) begin
            s_d.running = 1'b1;
            s_d.level = pulse_start_level;
            s_d.count = pulse_start_level ? high_len : low_len;
        end else if (s_q.count == 24'h00_0000) begin
            // zero count ends this phase: setting plus one cycles in total
            s_d.level = !s_q.level;
            s_d.count = s_q.level ? low_len : high_len;
        end else begin
            s_d.count = s_q.count - 24'h00_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign frame_pulse = s_q.level;
endmodule : fscfg_pulse_gen

// File: hdl/fscfg_top.sv
// Purpose: ahb-lite register slice for frame pulse timing, frame numbering,
//          lane rate and per-port forwarding
// Assumes: single word transfers; zero wait states; byte data in bits 7:0
// Notes: frame number output latched at frame start, held for the frame end
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module fscfg_top
    import fscfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic [1:0] port_video_valid,
    output logic frame_pulse,
    output logic [15:0] packet_frame_number,
    output logic packet_number_valid,
    output logic [1:0] lane_rate_select,
    output logic [1:0] port_forward_valid
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] high_upper;
        logic [7:0] high_lower;
        logic [7:0] low_upper;
        logic [7:0] low_lower;
        logic [7:0] limit_upper;
        logic [7:0] limit_lower;
        logic [7:0] rate;
        logic [7:0] fwd;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic [15:0] frame_cnt;
        logic [15:0] number;
        logic number_valid;
        logic [1:0] rate_out;
        logic [1:0] fwd_out;
        logic pulse;
    } fscfg_top_s;

    fscfg_top_s s_q, s_d;
    logic gen_pulse;
    logic addr_phase;
    logic [7:0] a_idx;
    logic [15:0] limit;
    logic [7:0] rd_byte;

    fscfg_pulse_gen u_gen (
        .core_clk(core_clk),
        .reset(reset),
        .pulse_generator_on(s_q.ctl[FSCFG_CTL_ENABLE_BIT]),
        .pulse_timing_style(s_q.ctl[FSCFG_CTL_STYLE_BIT]),
        .pulse_start_level(s_q.ctl[FSCFG_CTL_START_BIT]),
        .pulse_high_setting({s_q.high_upper, s_q.high_lower}),
        .pulse_low_setting({s_q.low_upper, s_q.low_lower}),
        .frame_pulse(gen_pulse)
    );

    always_comb begin
        addr_phase = hsel && hready && htrans == FSCFG_HTRANS_NONSEQ;
        a_idx = haddr[9:2];
        limit = {s_q.limit_upper, s_q.limit_lower};
        case (a_idx)
            FSCFG_IDX_CTL: rd_byte = s_q.ctl;
            FSCFG_IDX_HIGH_UPPER: rd_byte = s_q.high_upper;
            FSCFG_IDX_HIGH_LOWER: rd_byte = s_q.high_lower;
            FSCFG_IDX_LOW_UPPER: rd_byte = s_q.low_upper;
            FSCFG_IDX_LOW_LOWER: rd_byte = s_q.low_lower;
            FSCFG_IDX_LIMIT_UPPER: rd_byte = s_q.limit_upper;
            FSCFG_IDX_LIMIT_LOWER: rd_byte = s_q.limit_lower;
            FSCFG_IDX_RATE: rd_byte = s_q.rate;
            FSCFG_IDX_FWD: rd_byte = s_q.fwd;
            // live state: current frame number low byte
            FSCFG_IDX_STATUS: rd_byte = s_q.number[7:0];
            default: rd_byte = FSCFG_RST_ZERO;
        endcase
        s_d = s_q;
        // address phase captured; data taken one cycle later
        s_d.wr_pend = addr_phase && hwrite;
        if (addr_phase) begin
            s_d.wr_idx = a_idx;
        end
        if (addr_phase && !hwrite) begin
            s_d.rdata = {24'h00_0000, rd_byte};
        end
        if (s_q.wr_pend) begin
            case (s_q.wr_idx)
                FSCFG_IDX_CTL: s_d.ctl = hwdata[7:0] & FSCFG_CTL_MASK;
                FSCFG_IDX_HIGH_UPPER: s_d.high_upper = hwdata[7:0];
                FSCFG_IDX_HIGH_LOWER: s_d.high_lower = hwdata[7:0];
                FSCFG_IDX_LOW_UPPER: s_d.low_upper = hwdata[7:0];
                FSCFG_IDX_LOW_LOWER: s_d.low_lower = hwdata[7:0];
                FSCFG_IDX_LIMIT_UPPER: s_d.limit_upper = hwdata[7:0];
                FSCFG_IDX_LIMIT_LOWER: s_d.limit_lower = hwdata[7:0];
                // top nibble reads zero, bits 3:2 kept for software
                FSCFG_IDX_RATE: s_d.rate = hwdata[7:0] & FSCFG_RATE_MASK;
                FSCFG_IDX_FWD: s_d.fwd = hwdata[7:0] & FSCFG_FWD_MASK;
                default: s_d.rdata = s_q.rdata;
            endcase
        end
        // number advances only at frame start; frame end reuses it
        if (frame_start) begin
            if (limit == 16'h0000) begin
                s_d.frame_cnt = 16'h0000;
            end else if (s_q.frame_cnt >= limit || s_q.frame_cnt == 16'h0000) begin
                // >= also catches a limit lowered below the running count
                s_d.frame_cnt = 16'h0001;
            end else begin
                s_d.frame_cnt = s_q.frame_cnt + 16'h0001;
            end
            s_d.number = (limit == 16'h0000) ? 16'h0000 : s_d.frame_cnt;
        end
        s_d.number_valid = frame_start || frame_end;
        s_d.rate_out = s_q.rate[1:0];
        // port disable bits are active high
        s_d.fwd_out[0] = port_video_valid[0] && !s_q.fwd[FSCFG_FWD_PORT0_BIT];
        s_d.fwd_out[1] = port_video_valid[1] && !s_q.fwd[FSCFG_FWD_PORT1_BIT];
        s_d.pulse = gen_pulse;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.limit_lower <= FSCFG_RST_LIMIT_LOWER;
            s_q.rate <= FSCFG_RST_RATE;
            s_q.fwd <= FSCFG_RST_FWD;
            s_q.rate_out <= FSCFG_RST_RATE[1:0];
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign frame_pulse = s_q.pulse;
    assign packet_frame_number = s_q.number;
    assign packet_number_valid = s_q.number_valid;
    assign lane_rate_select = s_q.rate_out;
    assign port_forward_valid = s_q.fwd_out;

    logic [15:0] prev_number;
    always_ff @(posedge core_clk) begin
        prev_number <= s_q.number;
    end

    zero_limit_a: assert property (@(posedge core_clk) disable iff (reset)
        frame_start && limit == 16'h0000 |=> packet_frame_number == 16'h0000)
        else $error("frame number not zero with zero limit");
    count_start_a: assert property (@(posedge core_clk) disable iff (reset)
        frame_start && limit != 16'h0000 |=> packet_frame_number >= 16'h0001)
        else $error("frame number below one");
    count_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
        frame_start && limit != 16'h0000 && s_q.number >= limit |=> packet_frame_number == 16'h0001)
        else $error("frame number did not wrap to one");
    count_step_a: assert property (@(posedge core_clk) disable iff (reset)
        frame_start && limit != 16'h0000 && s_q.number != 16'h0000 && s_q.number < limit
        |=> packet_frame_number == prev_number + 16'h0001)
        else $error("frame number did not step by one");
    end_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        frame_end && !frame_start |=> packet_frame_number == prev_number && packet_number_valid)
        else $error("frame end changed the number");
    rate_follow_a: assert property (@(posedge core_clk) disable iff (reset)
        ##1 lane_rate_select == $past(s_q.rate[1:0]))
        else $error("lane rate does not follow register");
    fwd_block_a: assert property (@(posedge core_clk) disable iff (reset)
        s_q.fwd[FSCFG_FWD_PORT0_BIT] |=> !port_forward_valid[0])
        else $error("disabled port 0 forwarded");
    limit_write_a: assert property (@(posedge core_clk) disable iff (reset)
        s_q.wr_pend && s_q.wr_idx == FSCFG_IDX_LIMIT_LOWER |=> s_q.limit_lower == $past(hwdata[7:0]))
        else $error("limit low byte not written");
    high_write_a: assert property (@(posedge core_clk) disable iff (reset)
        s_q.wr_pend && s_q.wr_idx == FSCFG_IDX_HIGH_UPPER |=> s_q.high_upper == $past(hwdata[7:0]))
        else $error("high upper byte not written");
    low_write_a: assert property (@(posedge core_clk) disable iff (reset)
        s_q.wr_pend && s_q.wr_idx == FSCFG_IDX_LOW_LOWER |=> s_q.low_lower == $past(hwdata[7:0]))
        else $error("low lower byte not written");
    min_phase_a: assert property (@(posedge core_clk) disable iff (reset)
        s_q.ctl[FSCFG_CTL_ENABLE_BIT] && !s_q.ctl[FSCFG_CTL_STYLE_BIT] && $rose(gen_pulse)
        && {s_q.high_upper, s_q.high_lower} != 16'h0000 |=> gen_pulse)
        else $error("high phase shorter than its setting");
    start_level_a: assert property (@(posedge core_clk) disable iff (reset)
        !s_q.ctl[FSCFG_CTL_ENABLE_BIT] |=> gen_pulse == $past(s_q.ctl[FSCFG_CTL_START_BIT]))
        else $error("idle pulse not at start level");
endmodule : fscfg_top

// File: sim/fscfg_rx_model.sv
// Purpose: host receiver model, frames packets and captures frame numbers
// Assumes: frame number answered one cycle after the strobe edge
// Notes: idle gap between frames lets the bench vary the pacing
`timescale 1ns/1ns
module fscfg_rx_model (
    input wire logic core_clk,
    input wire logic [15:0] packet_frame_number,
    input wire logic packet_number_valid,
    output logic frame_start,
    output logic frame_end
);
    initial begin
        frame_start = 1'b0;
        frame_end = 1'b0;
    end
    // capture both packets of one frame
    task automatic frame(input int gap, output logic [15:0] fs_num, output logic [15:0] fe_num,
                         output logic [1:0] ok);
        repeat (gap) @(posedge core_clk);
        frame_start <= 1'b1;
        @(posedge core_clk);
        frame_start <= 1'b0;
        @(posedge core_clk);
        fs_num = packet_frame_number;
        ok[1] = packet_number_valid;
        frame_end <= 1'b1;
        @(posedge core_clk);
        frame_end <= 1'b0;
        @(posedge core_clk);
        fe_num = packet_frame_number;
        ok[0] = packet_number_valid;
    endtask : frame
endmodule : fscfg_rx_model

// File: sim/tb_top.sv
// Purpose: register, frame number and pulse timing checks over ahb-lite
// Assumes: zero wait slave, but every wait is bounded
// Notes: limit changes keep the running count, so expectation carries across
`timescale 1ns/1ns
module tb_top
    import fscfg_pkg::*;
;
    logic core_clk = 0, reset = 1, hsel = 0, hwrite = 0, hresp, hreadyout, frame_start, frame_end, frame_pulse;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, port_video_valid = 0, lane_rate_select, port_forward_valid, ok;
    logic [2:0] hsize = 0;
    logic [15:0] packet_frame_number, fs, fe, expn;
    logic packet_number_valid;
    int n_errors = 0, n_tests = 0, n;
    initial forever #5 core_clk = ~core_clk;
    fscfg_top fscfg_top_inst (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start), .frame_end(frame_end),
        .port_video_valid(port_video_valid), .frame_pulse(frame_pulse), .packet_frame_number(packet_frame_number),
        .packet_number_valid(packet_number_valid), .lane_rate_select(lane_rate_select),
        .port_forward_valid(port_forward_valid));
    fscfg_rx_model fscfg_rx_model_inst (.core_clk(core_clk), .packet_frame_number(packet_frame_number),
        .packet_number_valid(packet_number_valid), .frame_start(frame_start), .frame_end(frame_end));
    task automatic stop_test;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 100);
        if (i >= 100) begin
            n_errors++;
            stop_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h00_0000, idx, 2'b00};
        htrans <= FSCFG_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= FSCFG_HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h00_0000, exp});
    endtask : rdchk
    // count a whole phase at level lvl, starting from its leading edge
    task automatic phase_len(input logic lvl);
        n = 0;
        while (frame_pulse === lvl && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        while (frame_pulse !== lvl && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        while (frame_pulse === lvl && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
    endtask : phase_len
    task automatic frames(input logic [15:0] lim, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            expn = (lim == 16'h0000) ? 16'h0000 : ((expn == lim) ? 16'h0001 : expn + 16'h0001);
            fscfg_rx_model_inst.frame(i % 3, fs, fe, ok);
            chk({16'h0000, fs}, {16'h0000, expn});
            chk({16'h0000, fe}, {16'h0000, expn});
            chk({30'h0000_0000, ok}, 32'h0000_0003);
        end
    endtask : frames
    initial begin
        expn = 16'h0000;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 7; k++) rdchk(8'(FSCFG_IDX_HIGH_UPPER + k), (k == 5) ? 8'h04 : (k == 6) ? 8'h02 : 8'h00);
        chk(lane_rate_select, 32'h0000_0002);
        chk({hreadyout, hresp}, 32'h0000_0002);
        frames(16'h0004, 6);
        rdchk(FSCFG_IDX_STATUS, 8'h02);
        bus(1'b1, FSCFG_IDX_LIMIT_UPPER, 8'h01);
        bus(1'b1, FSCFG_IDX_LIMIT_LOWER, 8'h00);
        frames(16'h0100, 256);
        bus(1'b1, FSCFG_IDX_LIMIT_UPPER, 8'h00);
        frames(16'h0000, 2);
        for (int k = 0; k < 6; k++) bus(1'b1, 8'(FSCFG_IDX_HIGH_UPPER + k), 8'ha5 ^ k[7:0]);
        for (int k = 0; k < 6; k++) rdchk(8'(FSCFG_IDX_HIGH_UPPER + k), 8'ha5 ^ k[7:0]);
        bus(1'b1, FSCFG_IDX_RATE, 8'hff);
        rdchk(FSCFG_IDX_RATE, 8'h0f);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, FSCFG_IDX_RATE, c[7:0]);
            // register lands at the data edge, the output flop one edge later
            repeat (2) @(posedge core_clk);
            chk(lane_rate_select, {30'h0000_0000, c[1:0]});
        end
        bus(1'b1, 8'h30, 8'hff);
        rdchk(8'h30, 8'h00);
        rdchk(FSCFG_IDX_FWD, FSCFG_RST_FWD);
        port_video_valid <= 2'b11;
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, FSCFG_IDX_FWD, (k == 0) ? 8'h30 : (k == 1) ? 8'h20 : 8'h10);
            repeat (2) @(posedge core_clk);
            chk(port_forward_valid, {30'h0000_0000, k[1:0]});
        end
        bus(1'b1, FSCFG_IDX_HIGH_UPPER, 8'h01);
        bus(1'b1, FSCFG_IDX_HIGH_LOWER, 8'h00);
        bus(1'b1, FSCFG_IDX_LOW_UPPER, 8'h00);
        bus(1'b1, FSCFG_IDX_LOW_LOWER, 8'h02);
        bus(1'b1, FSCFG_IDX_CTL, 8'h01);
        phase_len(1'b1);
        chk(n, 257);
        phase_len(1'b0);
        chk(n, 3);
        bus(1'b1, FSCFG_IDX_CTL, 8'h03);
        phase_len(1'b1);
        phase_len(1'b1);
        chk(n, 3);
        phase_len(1'b0);
        chk(n, 3);
        bus(1'b1, FSCFG_IDX_CTL, 8'h04);
        repeat (3) @(posedge core_clk);
        chk({31'h0000_0000, frame_pulse}, 32'h0000_0001);
        rdchk(FSCFG_IDX_CTL, 8'h04);
        bus(1'b1, FSCFG_IDX_CTL, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({31'h0000_0000, frame_pulse}, 32'h0000_0000);
        stop_test();
    end
endmodule : tb_top
